// File: hw/bbn_pkg.sv
// Constants for the bridge bus number register block
//
// Behaviour
// - Status bit 6 user feature reads zero
// - Status bit 5 fast clock reads zero
// - Status bits 4 to 0 read zero
// - Some status bits cleared only by global reset or by a write of one
// - Upstream bus index at 18h, reset 00h
// - Downstream bus index at 19h, reset 00h
// - Highest downstream index at 1Ah, reset 00h
// - Three indices decide config cycle forwarding
package bbn_pkg;
	// ----------------------------------------
	// Register offsets and widths
	// ----------------------------------------
	localparam int         ADDR_W          = 8;
	localparam int         IDX_W           = 8;
	localparam int         STAT_W          = 16;
	localparam logic [7:0] OFS_UPSTREAM    = 8'h18;
	localparam logic [7:0] OFS_DOWNSTREAM  = 8'h19;
	localparam logic [7:0] OFS_HIGHEST     = 8'h1A;
	localparam logic [7:0] OFS_SEC_STATUS  = 8'h16;
	localparam logic [7:0] IDX_RESET       = 8'h00;
	// ----------------------------------------
	// Secondary status fields
	// ----------------------------------------
	localparam int          STAT_STICKY_LSB = 8;
	localparam int          STAT_STICKY_W   = 8;
	localparam logic [7:0]  STICKY_RESET    = 8'h00;
	localparam int          USER_FEAT_BIT   = 6;
	localparam int          FAST_CLK_BIT    = 5;
	localparam logic [15:0] STAT_LOW_ZERO   = 16'h0000;
	// ----------------------------------------
	// Forwarding decision codes
	// ----------------------------------------
	typedef enum logic [1:0] {
		BBN_FWD_NONE  = 2'b00,
		BBN_FWD_TYPE0 = 2'b01,
		BBN_FWD_TYPE1 = 2'b11
	} bbn_fwd_t;
endpackage

// File: hw/bbn_regs.sv
// Bus number registers, secondary status and forwarding decision
`timescale 1ns/100ps
module bbn_regs (
	// Clock and resets
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	input  wire logic                      global_reset,
	// Register port
	input  wire logic [bbn_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	// Hardware status events
	input  wire logic [bbn_pkg::STAT_STICKY_W-1:0] stat_set,
	// Configuration cycle lookup
	input  wire logic                       cfg_valid,
	input  wire logic [bbn_pkg::IDX_W-1:0]  cfg_bus,
	output logic                            fwd_valid,
	output bbn_pkg::bbn_fwd_t               fwd_kind,
	// Register views
	output logic [bbn_pkg::IDX_W-1:0]       upstream_bus_index,
	output logic [bbn_pkg::IDX_W-1:0]       downstream_bus_index,
	output logic [bbn_pkg::IDX_W-1:0]       highest_downstream_bus_index
);
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic sel_up   = (reg_addr == bbn_pkg::OFS_UPSTREAM);
	wire logic sel_down = (reg_addr == bbn_pkg::OFS_DOWNSTREAM);
	wire logic sel_high = (reg_addr == bbn_pkg::OFS_HIGHEST);
	wire logic sel_slo  = (reg_addr == bbn_pkg::OFS_SEC_STATUS);
	wire logic sel_shi  = (reg_addr == bbn_pkg::OFS_SEC_STATUS + 8'h01);

	// Sticky upper status byte, write one to clear
	logic [bbn_pkg::STAT_STICKY_W-1:0] sticky_reg;
	logic [bbn_pkg::STAT_STICKY_W-1:0] sticky_next;
	wire logic [7:0] sticky_clr = (reg_wr && sel_shi) ? reg_wdata : 8'h00;
	// Set wins over a clear in the same cycle
	assign sticky_next = (sticky_reg & ~sticky_clr) | stat_set;

	// Low status byte: bits 6, 5 and 4..0 are constant zero
	wire logic [15:0] sec_status = {sticky_reg,
		bbn_pkg::STAT_LOW_ZERO[7:0]};

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			upstream_bus_index           <= bbn_pkg::IDX_RESET;
			downstream_bus_index         <= bbn_pkg::IDX_RESET;
			highest_downstream_bus_index <= bbn_pkg::IDX_RESET;
		end else if (reg_wr) begin
			if (sel_up)
				upstream_bus_index <= reg_wdata;
			if (sel_down)
				downstream_bus_index <= reg_wdata;
			if (sel_high)
				highest_downstream_bus_index <= reg_wdata;
		end
	end

	// Lesser reset leaves these bits alone
	always_ff @(posedge clk_sys) begin
		if (global_reset)
			sticky_reg <= bbn_pkg::STICKY_RESET;
		else
			sticky_reg <= sticky_next;
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire logic [7:0] rd_mux =
		sel_up   ? upstream_bus_index :
		sel_down ? downstream_bus_index :
		sel_high ? highest_downstream_bus_index :
		sel_slo  ? sec_status[7:0] :
		sel_shi  ? sec_status[15:8] : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (reset)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// ----------------------------------------
	// Forwarding decision
	// ----------------------------------------
	// Unprogrammed registers all read zero, so nothing forwards
	// A cycle aimed at the upstream bus itself never goes downstream
	wire logic own_bus = (cfg_bus == upstream_bus_index);
	wire logic hit_t0  = !own_bus &&
		(cfg_bus == downstream_bus_index);
	wire logic hit_t1  = !own_bus &&
		(cfg_bus > downstream_bus_index) &&
		(cfg_bus <= highest_downstream_bus_index);
	wire bbn_pkg::bbn_fwd_t kind_next = hit_t0 ? bbn_pkg::BBN_FWD_TYPE0 :
		hit_t1 ? bbn_pkg::BBN_FWD_TYPE1 : bbn_pkg::BBN_FWD_NONE;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fwd_valid <= 1'b0;
			fwd_kind  <= bbn_pkg::BBN_FWD_NONE;
		end else begin
			fwd_valid <= cfg_valid;
			fwd_kind  <= cfg_valid ? kind_next : bbn_pkg::BBN_FWD_NONE;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_status_low_zero: assert property (@(posedge clk_sys) disable iff (reset)
		reg_rd && sel_slo |=> reg_rdata == 8'h00)
		else $error("status low byte not zero");
	a_upstream_write: assert property (@(posedge clk_sys) disable iff (reset)
		reg_wr && sel_up |=> upstream_bus_index == $past(reg_wdata))
		else $error("upstream index not written");
	a_downstream_read: assert property (@(posedge clk_sys) disable iff (reset)
		reg_rd && sel_down |=> reg_rdata == $past(downstream_bus_index))
		else $error("downstream index read wrong");
	a_highest_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!(reg_wr && sel_high) |=> $stable(highest_downstream_bus_index))
		else $error("highest index changed without write");
	a_sticky_hold: assert property (@(posedge clk_sys)
		reset && !global_reset && stat_set == 8'h00
		&& !(reg_wr && sel_shi) |=> $stable(sticky_reg))
		else $error("sticky status cleared by lesser reset");
	a_fwd_type0: assert property (@(posedge clk_sys) disable iff (reset)
		cfg_valid && cfg_bus == downstream_bus_index
		&& cfg_bus != upstream_bus_index
		|=> fwd_valid && fwd_kind == bbn_pkg::BBN_FWD_TYPE0)
		else $error("type 0 forward missed");
	a_fwd_type1: assert property (@(posedge clk_sys) disable iff (reset)
		cfg_valid && cfg_bus > downstream_bus_index
		&& cfg_bus <= highest_downstream_bus_index
		&& cfg_bus != upstream_bus_index
		|=> fwd_kind == bbn_pkg::BBN_FWD_TYPE1)
		else $error("type 1 forward missed");
	a_fwd_none: assert property (@(posedge clk_sys) disable iff (reset)
		cfg_valid && cfg_bus < downstream_bus_index
		|=> fwd_kind == bbn_pkg::BBN_FWD_NONE)
		else $error("forwarded below secondary");
	a_fwd_own: assert property (@(posedge clk_sys) disable iff (reset)
		cfg_valid && cfg_bus == upstream_bus_index
		|=> fwd_valid && fwd_kind == bbn_pkg::BBN_FWD_NONE)
		else $error("upstream bus cycle forwarded");
	a_fwd_idle: assert property (@(posedge clk_sys) disable iff (reset)
		!cfg_valid |=> !fwd_valid && fwd_kind == bbn_pkg::BBN_FWD_NONE)
		else $error("forward result without request");
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read strobe");

	// Hardware event seen while the global reset is released
	sequence s_sticky_event;
		!global_reset && stat_set != 8'h00;
	endsequence
	// Read of the upper status byte
	sequence s_status_high_read;
		reg_rd && sel_shi;
	endsequence

	a_sticky_set: assert property (@(posedge clk_sys)
		s_sticky_event
		|=> (sticky_reg & $past(stat_set)) == $past(stat_set))
		else $error("status event lost");
	a_global_clear: assert property (@(posedge clk_sys)
		global_reset |=> sticky_reg == bbn_pkg::STICKY_RESET)
		else $error("global reset did not clear status");
	a_status_high_read: assert property (@(posedge clk_sys)
		disable iff (reset)
		s_status_high_read |=> reg_rdata == $past(sticky_reg))
		else $error("status high byte read wrong");
endmodule

// File: tb/bbn_regs_tb.sv
// Self-checking bench for the bus number register block
`timescale 1ns/100ps
module bbn_regs_tb;
	logic              clk_sys = 1'b0;
	logic              reset = 1'b1;
	logic              global_reset = 1'b1;
	logic [7:0]        reg_addr = 8'h00;
	logic [7:0]        reg_wdata = 8'h00;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [7:0]        stat_set = 8'h00;
	logic              cfg_valid = 1'b0;
	logic [7:0]        cfg_bus = 8'h00;
	logic [7:0]        reg_rdata;
	logic              fwd_valid;
	bbn_pkg::bbn_fwd_t fwd_kind;
	logic [7:0]        up_view;
	logic [7:0]        down_view;
	logic [7:0]        high_view;
	int                err_total = 0;
	int                num_checks = 0;
	always #4 clk_sys = ~clk_sys;
	bbn_regs uut (.clk_sys(clk_sys), .reset(reset),
		.global_reset(global_reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .stat_set(stat_set), .cfg_valid(cfg_valid),
		.cfg_bus(cfg_bus), .fwd_valid(fwd_valid), .fwd_kind(fwd_kind),
		.upstream_bus_index(up_view), .downstream_bus_index(down_view),
		.highest_downstream_bus_index(high_view));
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic fwd(input logic [7:0] b, input bbn_pkg::bbn_fwd_t k);
		@(posedge clk_sys);
		cfg_bus   <= b;
		cfg_valid <= 1'b1;
		@(posedge clk_sys);
		cfg_valid <= 1'b0;
		#1;
		chk({7'h00, fwd_valid}, 8'h01);
		chk({6'h00, fwd_kind}, {6'h00, k});
		@(posedge clk_sys);
		#1;
		chk({7'h00, fwd_valid}, 8'h00);
		chk({6'h00, fwd_kind}, 8'h00);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		#20000;
		err_total++;
		tally_and_finish;
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		reset        <= 1'b0;
		global_reset <= 1'b0;
		rd(8'h18, 8'h00);
		rd(8'h19, 8'h00);
		rd(8'h1A, 8'h00);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h00);
		rd(8'h40, 8'h00);
		fwd(8'h00, bbn_pkg::BBN_FWD_NONE);
		wr(8'h18, 8'h03);
		wr(8'h19, 8'h05);
		wr(8'h1A, 8'h08);
		rd(8'h18, 8'h03);
		rd(8'h19, 8'h05);
		rd(8'h1A, 8'h08);
		chk(up_view, 8'h03);
		chk(down_view, 8'h05);
		chk(high_view, 8'h08);
		fwd(8'h03, bbn_pkg::BBN_FWD_NONE);
		fwd(8'h05, bbn_pkg::BBN_FWD_TYPE0);
		fwd(8'h06, bbn_pkg::BBN_FWD_TYPE1);
		fwd(8'h08, bbn_pkg::BBN_FWD_TYPE1);
		fwd(8'h09, bbn_pkg::BBN_FWD_NONE);
		fwd(8'h04, bbn_pkg::BBN_FWD_NONE);
		@(posedge clk_sys);
		stat_set <= 8'hA5;
		@(posedge clk_sys);
		stat_set <= 8'h00;
		rd(8'h17, 8'hA5);
		@(posedge clk_sys);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(8'h17, 8'hA5);
		rd(8'h19, 8'h00);
		chk(up_view, 8'h00);
		chk(high_view, 8'h00);
		wr(8'h17, 8'h05);
		rd(8'h17, 8'hA0);
		@(posedge clk_sys);
		stat_set  <= 8'h01;
		reg_addr  <= 8'h17;
		reg_wdata <= 8'hFF;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		stat_set  <= 8'h00;
		reg_wr    <= 1'b0;
		rd(8'h17, 8'h01);
		@(posedge clk_sys);
		global_reset <= 1'b1;
		@(posedge clk_sys);
		global_reset <= 1'b0;
		rd(8'h17, 8'h00);
		tally_and_finish;
	end
endmodule
